// *** logic/rbf_defines.vh ***
`ifndef RBF_DEFINES_VH
`define RBF_DEFINES_VH
// Register addresses
`define RBF_ADDR_CTRL 8'h58
`define RBF_ADDR_EOF 8'h59
`define RBF_ADDR_SOFH 8'h5A
`define RBF_ADDR_SOFL 8'h5B
`define RBF_ADDR_SYNC 8'h5C
`define RBF_ADDR_STAT 8'h60
`define RBF_ADDR_MASK 8'h61
`define RBF_ADDR_DATA 8'h62
`define RBF_ADDR_CMD 8'h63
// Control field positions
`define RBF_BIT_BADPAR 5
`define RBF_BIT_LENSTOP 4
`define RBF_BIT_MSB 3
`define RBF_BIT_STOPEN 2
`define RBF_BIT_ODDPAR 1
`define RBF_CTRL_MASK 8'h3E
// Status bits
`define RBF_ST_BYTE 0
`define RBF_ST_DONE 1
`define RBF_ST_FERR 2
`define RBF_ST_PERR 3
`define RBF_ST_SOF 4
// Reset values
`define RBF_CTRL_RST 8'h00
`define RBF_EOF_RST 8'h00
`define RBF_SYNC_RST 8'h00
`define RBF_SOF_RST 8'h00
`define RBF_TIMEOUT_BITS 32
`endif

// *** logic/rbf_sof_match.v ***
`timescale 1ns/100ps
`default_nettype none
// Start-of-frame comparator over a shift history of received bits
module rbf_sof_match (
  // Pattern
  input wire [15:0] i_pattern,
  input wire [3:0] i_valid_len,
  input wire [1:0] i_interp,
  // History, newest bit in bit 0
  input wire [15:0] i_hist,
  input wire [3:0] i_seen,
  // Result
  output reg o_match
);
  integer k;
  reg ok;
  // Type 0 compares bits, type 1 compares pairs with collision don't-care
  always @* begin
    ok = 1'b1;
    for (k = 0; k < 16; k = k + 1) begin
      if (i_interp == 2'd1) begin
        if ((k < i_valid_len) && !i_pattern[2*(k%8)]) begin
          if (i_hist[k%16] != i_pattern[2*(k%8)+1]) ok = 1'b0;
        end
      end else if ((k < i_valid_len) && (i_hist[k] != i_pattern[k])) begin
        ok = 1'b0;
      end
    end
    o_match = ok && (i_seen >= i_valid_len);
  end
endmodule
`default_nettype wire

// *** logic/rbf_eof_match.v ***
`timescale 1ns/100ps
`default_nettype none
// End-of-frame symbol tracker: walks tuples from bits 1:0 upward
module rbf_eof_match (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [7:0] i_pattern,
  input wire i_clear,
  input wire i_bit_valid,
  input wire i_bit,
  input wire i_bit_coll,
  output wire o_enabled,
  output reg o_hit
);
  reg [2:0] pos_reg;
  wire [1:0] tup;
  wire last;
  wire good;
  assign tup = (pos_reg == 3'd0) ? i_pattern[1:0] : (pos_reg == 3'd1) ? i_pattern[3:2] :
               (pos_reg == 3'd2) ? i_pattern[5:4] : i_pattern[7:6];
  assign o_enabled = (i_pattern[1:0] != 2'b00);
  // Next tuple zero or fourth tuple closes the symbol
  assign last = (pos_reg == 3'd3) || ((pos_reg == 3'd0) ? (i_pattern[3:2] == 2'b00) :
                (pos_reg == 3'd1) ? (i_pattern[5:4] == 2'b00) : (i_pattern[7:6] == 2'b00));
  // 1 zero, 2 one, 3 collision
  assign good = (tup == 2'd3) ? i_bit_coll : (!i_bit_coll && (i_bit == tup[1]));
  // Match in tuple order; restart on mismatch
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos_reg <= 3'd0;
      o_hit <= 1'b0;
    end else begin
      o_hit <= 1'b0;
      if (i_clear) begin
        pos_reg <= 3'd0;
      end else if (i_bit_valid && o_enabled) begin
        if (good && last) begin
          o_hit <= 1'b1;
          pos_reg <= 3'd0;
        end else if (good) begin
          pos_reg <= pos_reg + 3'd1;
        end else begin
          pos_reg <= 3'd0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/rbf_rx_framer.v ***
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "rbf_defines.vh"
module rbf_rx_framer (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Demodulator bits
  input wire i_bit_valid,
  input wire i_bit,
  input wire i_bit_coll,
  output reg o_demod_reset,
  // Host data path
  output reg [7:0] o_byte,
  output reg o_byte_valid,
  output reg o_frame_done,
  output reg o_frame_error,
  // Interrupt
  output wire o_irq
);
  localparam S_IDLE = 4'b0001;
  localparam S_SOF = 4'b0010;
  localparam S_DATA = 4'b0100;
  localparam S_DONE = 4'b1000;
  localparam PH_DATA = 2'd0;
  localparam PH_PAR = 2'd1;
  localparam PH_STOP = 2'd2;

  reg [7:0] ctrl_reg;
  reg [7:0] eof_reg;
  reg [7:0] sofh_reg;
  reg [7:0] sofl_reg;
  reg [7:0] sync_reg;
  reg [4:0] stat_reg;
  reg [4:0] mask_reg;
  reg [3:0] state_reg;
  reg [15:0] hist_reg;
  reg [3:0] seen_reg;
  reg [7:0] shift_reg;
  reg [2:0] bitcnt_reg;
  reg [1:0] phase_reg;
  reg [7:0] bytes_reg;
  reg [7:0] len_reg;
  reg got_len_reg;
  reg [4:0] set_ev;
  reg [7:0] byte_next;
  wire sof_hit;
  wire eof_hit;
  wire eof_en;
  wire start_cmd;
  wire par_exp;

  assign start_cmd = i_wr && (i_addr == `RBF_ADDR_CMD) && i_wdata[0];
  assign o_irq = |(stat_reg & mask_reg);
  // Expected parity bit over data: even makes total even
  assign par_exp = (^byte_next) ^ ctrl_reg[`RBF_BIT_ODDPAR];

  rbf_sof_match u_sof (
    .i_pattern({sofh_reg, sofl_reg}),
    .i_valid_len(sync_reg[7:4]),
    .i_interp(sync_reg[1:0]),
    .i_hist(hist_reg),
    .i_seen(seen_reg),
    .o_match(sof_hit)
  );

  rbf_eof_match u_eof (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_pattern(eof_reg),
    .i_clear(state_reg != S_DATA),
    .i_bit_valid(i_bit_valid && (state_reg == S_DATA) && (phase_reg == PH_DATA)),
    .i_bit(i_bit),
    .i_bit_coll(i_bit_coll),
    .o_enabled(eof_en),
    .o_hit(eof_hit)
  );

  // Byte assembly in selected order
  always @* begin
    if (ctrl_reg[`RBF_BIT_MSB])
      byte_next = shift_reg;
    else
      byte_next = {shift_reg[0], shift_reg[1], shift_reg[2], shift_reg[3],
                   shift_reg[4], shift_reg[5], shift_reg[6], shift_reg[7]};
  end

  // Register writes
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= `RBF_CTRL_RST;
      eof_reg <= `RBF_EOF_RST;
      sofh_reg <= `RBF_SOF_RST;
      sofl_reg <= `RBF_SOF_RST;
      sync_reg <= `RBF_SYNC_RST;
      mask_reg <= 5'h00;
    end else if (i_wr) begin
      case (i_addr)
        `RBF_ADDR_CTRL: ctrl_reg <= i_wdata & `RBF_CTRL_MASK;
        `RBF_ADDR_EOF: eof_reg <= i_wdata;
        `RBF_ADDR_SOFH: sofh_reg <= i_wdata;
        `RBF_ADDR_SOFL: sofl_reg <= i_wdata;
        `RBF_ADDR_SYNC: sync_reg <= i_wdata;
        `RBF_ADDR_MASK: mask_reg <= i_wdata[4:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // Read data one cycle after the strobe
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `RBF_ADDR_CTRL: o_rdata <= ctrl_reg;
        `RBF_ADDR_EOF: o_rdata <= eof_reg;
        `RBF_ADDR_SOFH: o_rdata <= sofh_reg;
        `RBF_ADDR_SOFL: o_rdata <= sofl_reg;
        `RBF_ADDR_SYNC: o_rdata <= sync_reg;
        `RBF_ADDR_STAT: o_rdata <= {3'h0, stat_reg};
        `RBF_ADDR_MASK: o_rdata <= {3'h0, mask_reg};
        `RBF_ADDR_DATA: o_rdata <= o_byte;
        `RBF_ADDR_CMD: o_rdata <= {4'h0, state_reg};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Sticky status; a new event wins over the clear-on-read
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      stat_reg <= 5'h00;
    else if (i_rd && (i_addr == `RBF_ADDR_STAT))
      stat_reg <= set_ev;
    else
      stat_reg <= stat_reg | set_ev;
  end

  // Framing state machine
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= S_IDLE;
      hist_reg <= 16'h0000;
      seen_reg <= 4'h0;
      shift_reg <= 8'h00;
      bitcnt_reg <= 3'd0;
      phase_reg <= PH_DATA;
      bytes_reg <= 8'h00;
      len_reg <= 8'h00;
      got_len_reg <= 1'b0;
      o_byte <= 8'h00;
      o_byte_valid <= 1'b0;
      o_frame_done <= 1'b0;
      o_frame_error <= 1'b0;
      o_demod_reset <= 1'b0;
      set_ev <= 5'h00;
    end else begin
      o_byte_valid <= 1'b0;
      o_frame_done <= 1'b0;
      o_demod_reset <= 1'b0;
      set_ev <= 5'h00;
      // A start restarts from any state, so a frame with no stop condition cannot wedge us
      if (start_cmd && (state_reg != S_IDLE)) begin
        state_reg <= S_SOF;
        hist_reg <= 16'h0000;
        seen_reg <= 4'h0;
        o_frame_error <= 1'b0;
      end else begin
      case (state_reg)
        S_IDLE: begin
          if (start_cmd) begin
            state_reg <= S_SOF;
            hist_reg <= 16'h0000;
            seen_reg <= 4'h0;
            o_frame_error <= 1'b0;
          end
        end
        S_SOF: begin
          // Data only after the start pattern
          if (sof_hit) begin
            state_reg <= S_DATA;
            bitcnt_reg <= 3'd0;
            phase_reg <= PH_DATA;
            bytes_reg <= 8'h00;
            got_len_reg <= 1'b0;
            set_ev[`RBF_ST_SOF] <= 1'b1;
          end else if (i_bit_valid) begin
            hist_reg <= {hist_reg[14:0], i_bit};
            if (seen_reg != 4'hF)
              seen_reg <= seen_reg + 4'h1;
          end
        end
        S_DATA: begin
          if (eof_hit && eof_en) begin
            state_reg <= S_DONE;
          end else if (i_bit_valid) begin
            case (phase_reg)
              PH_DATA: begin
                shift_reg <= {shift_reg[6:0], i_bit};
                bitcnt_reg <= bitcnt_reg + 3'd1;
                if (bitcnt_reg == 3'd7)
                  phase_reg <= PH_PAR;
              end
              PH_PAR: begin
                o_byte <= byte_next;
                o_byte_valid <= 1'b1;
                set_ev[`RBF_ST_BYTE] <= 1'b1;
                bytes_reg <= bytes_reg + 8'h01;
                if (!got_len_reg) begin
                  len_reg <= byte_next;
                  got_len_reg <= 1'b1;
                end
                phase_reg <= ctrl_reg[`RBF_BIT_STOPEN] ? PH_STOP : PH_DATA;
                if (i_bit != par_exp) begin
                  set_ev[`RBF_ST_PERR] <= 1'b1;
                  if (ctrl_reg[`RBF_BIT_BADPAR])
                    state_reg <= S_DONE;
                end
                if (ctrl_reg[`RBF_BIT_LENSTOP] &&
                    ((got_len_reg ? len_reg : byte_next) == bytes_reg + 8'h01))
                  state_reg <= S_DONE;
              end
              PH_STOP: begin
                phase_reg <= PH_DATA;
                if (i_bit) begin
                  o_demod_reset <= 1'b1;
                end else begin
                  o_frame_error <= 1'b1;
                  set_ev[`RBF_ST_FERR] <= 1'b1;
                  state_reg <= S_DONE;
                end
              end
              default: phase_reg <= PH_DATA;
            endcase
          end
        end
        S_DONE: begin
          o_frame_done <= 1'b1;
          set_ev[`RBF_ST_DONE] <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** test/rbf_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module rbf_chk (
  // Clock, reset, register port
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // Bits and host side
  input wire i_bit_valid,
  input wire i_bit,
  input wire o_demod_reset,
  input wire o_byte_valid,
  input wire o_frame_done,
  input wire o_frame_error,
  input wire o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Control write then read in the very next cycle
  sequence s_ctrl_wr;
    i_wr && i_addr == 8'h58;
  endsequence
  sequence s_ctrl_rd;
    i_rd && !i_wr && i_addr == 8'h58;
  endsequence
  a_ctrl_readback: assert property (s_ctrl_wr ##1 s_ctrl_rd |=> o_rdata == ($past(i_wdata, 2) & 8'h3E))
    else $error("control readback wrong");
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (i_rd && i_addr == 8'h70 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_byte_cause: assert property (o_byte_valid |-> $past(i_bit_valid))
    else $error("byte without a bit strobe");
  a_demod_cause: assert property (o_demod_reset |-> $past(i_bit_valid && i_bit))
    else $error("demodulator reset without stop bit");
  a_err_cause: assert property ($rose(o_frame_error) |-> $past(i_bit_valid && !i_bit))
    else $error("frame error without zero stop bit");
  a_done_pulse: assert property (o_frame_done |=> !o_frame_done)
    else $error("frame done longer than a cycle");
  a_mask_off: assert property (i_wr && i_addr == 8'h61 && i_wdata == 8'h00 |=> !o_irq)
    else $error("interrupt despite zero mask");
endmodule
bind rbf_rx_framer rbf_chk rbf_chk_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_bit_valid(i_bit_valid), .i_bit(i_bit), .o_demod_reset(o_demod_reset),
  .o_byte_valid(o_byte_valid), .o_frame_done(o_frame_done), .o_frame_error(o_frame_error),
  .o_irq(o_irq));
`default_nettype wire

// *** test/rbf_card.sv ***
`timescale 1ns/100ps
`default_nettype none
// Card side: plays queued {coll, bit} pairs, one strobe each, with gap+1 idle cycles between strobes
module rbf_card (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Demodulated bits
  output logic o_bit_valid,
  output logic o_bit,
  output logic o_bit_coll
);
  logic [1:0] q[$];
  int gap = 1;
  int wait_cnt = 0;
  // Off-strobe the line shows the inverse bit, so a late sample is caught
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bit_valid <= 1'b0;
      o_bit <= 1'b0;
      o_bit_coll <= 1'b0;
    end else if (o_bit_valid) begin
      o_bit_valid <= 1'b0;
      o_bit <= ~o_bit;
      o_bit_coll <= 1'b0;
      wait_cnt <= gap;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (q.size() > 0) begin
      o_bit_valid <= 1'b1;
      {o_bit_coll, o_bit} <= q.pop_front();
    end
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  // Clock, reset, register port
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  // Design outputs and card bits
  wire [7:0] o_rdata;
  wire [7:0] o_byte;
  wire i_bit_valid;
  wire i_bit;
  wire i_bit_coll;
  wire o_demod_reset;
  wire o_byte_valid;
  wire o_frame_done;
  wire o_frame_error;
  wire o_irq;
  // Bench state
  int mismatches = 0;
  int n_checks = 0;
  int seed = 63731;
  int n_done = 0;
  int n_dres = 0;
  logic [7:0] got[$];
  logic [7:0] want[$];
  rbf_rx_framer rbf_rx_framer_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bit_valid(i_bit_valid),
    .i_bit(i_bit), .i_bit_coll(i_bit_coll), .o_demod_reset(o_demod_reset), .o_byte(o_byte),
    .o_byte_valid(o_byte_valid), .o_frame_done(o_frame_done), .o_frame_error(o_frame_error),
    .o_irq(o_irq));
  rbf_card rbf_card_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .o_bit_valid(i_bit_valid),
    .o_bit(i_bit), .o_bit_coll(i_bit_coll));
  initial forever #25 i_ref_clk = ~i_ref_clk;
  // Collect bytes, frame ends and resync pulses
  always @(posedge i_ref_clk) begin
    if (o_byte_valid === 1'b1) got.push_back(o_byte);
    if (o_frame_done === 1'b1) n_done++;
    if (o_demod_reset === 1'b1) n_dres++;
  end
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // One bus cycle; strobes stay up across back-to-back calls
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    #1 d = o_rdata;
  endtask
  // Data bits, parity (even: xor of data), then a stop bit if enabled
  task automatic send(input logic [7:0] c, input logic [7:0] b, input bit bp, input bit bs);
    for (int i = 0; i < 8; i++) rbf_card_i.q.push_back({1'b0, c[3] ? b[7 - i] : b[i]});
    rbf_card_i.q.push_back({1'b0, ^b ^ c[1] ^ bp});
    if (c[2]) rbf_card_i.q.push_back({1'b0, ~bs});
    want.push_back(b);
  endtask
  // Configure, start, and play a random start pattern of random valid length
  task automatic start(input logic [7:0] c, input logic [7:0] eof);
    logic [31:0] r;
    r = $random(seed);
    rbf_card_i.gap = r[21:20];
    wr(8'h58, c);
    wr(8'h59, eof);
    wr(8'h5C, {r[19:16], 4'h0});
    wr(8'h5A, r[15:8]);
    wr(8'h5B, r[7:0]);
    wr(8'h63, 8'h01);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    got.delete();
    want.delete();
    n_done = 0;
    n_dres = 0;
    for (int i = r[19:16] - 1; i >= 0; i--) rbf_card_i.q.push_back({1'b0, r[i]});
  endtask
  task automatic drain;
    for (int i = 0; i < 3000 && rbf_card_i.q.size() > 0; i++) @(posedge i_ref_clk);
    repeat (10) @(posedge i_ref_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    mismatches++;
    results();
  end
  initial begin
    logic [7:0] c;
    logic [7:0] d;
    logic [31:0] r;
    logic [7:0] eofs[4] = '{8'h1D, 8'h1D, 8'h06, 8'hE8};
    logic [5:0] seqs[4] = '{6'b001000, 6'b000010, 6'b010001, 6'b010110};
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    wr(8'h58, 8'hFF);
    rd(8'h58, d);
    chk(d === 8'h3E, "ctrl readback");
    for (int a = 8'h59; a <= 8'h5B; a++) begin
      r = $random(seed);
      wr(a[7:0], r[7:0]);
      rd(a[7:0], d);
      chk(d === r[7:0], "register readback");
    end
    rd(8'h70, d);
    chk(d === 8'h00, "unmapped read");
    $display("registers done");
    for (int f = 0; f < 6; f++) begin
      r = $random(seed);
      c = {4'h0, r[2:0], 1'b0};
      wr(8'h61, 8'h01);
      start(c, 8'h00);
      for (int k = 0; k < 4; k++) send(c, r[8 * k +: 8], 1'b0, 1'b0);
      drain();
      chk(got == want, "bytes wrong");
      chk(n_dres == (c[2] ? 4 : 0), "resync count");
      chk(o_irq === 1'b1, "irq not raised");
      rd(8'h60, d);
      chk(d[0] === 1'b1, "byte status");
      chk(o_irq === 1'b0, "irq not cleared");
      wr(8'h61, 8'h00);
    end
    $display("random frames done");
    start(8'h04, 8'h00);
    send(8'h04, 8'hA5, 1'b0, 1'b0);
    send(8'h04, 8'h3C, 1'b0, 1'b1);
    send(8'h04, 8'h0F, 1'b0, 1'b0);
    drain();
    chk(o_frame_error === 1'b1 && got.size() == 2, "bad stop");
    $display("bad stop done");
    start(8'h10, 8'h00);
    for (int k = 0; k < 5; k++) send(8'h10, k == 0 ? 8'h03 : 8'h5A, 1'b0, 1'b0);
    drain();
    chk(n_done == 1 && got.size() == 3, "length stop");
    $display("length stop done");
    for (int k = 0; k < 2; k++) begin
      c = k ? 8'h20 : 8'h00;
      start(c, 8'h00);
      send(c, 8'h11, 1'b0, 1'b0);
      send(c, 8'h22, 1'b1, 1'b0);
      send(c, 8'h33, 1'b0, 1'b0);
      drain();
      chk(n_done == k && got.size() == (k ? 2 : 3), "parity stop");
    end
    $display("parity stop done");
    for (int k = 0; k < 4; k++) begin
      start(8'h00, eofs[k]);
      for (int i = 2; i >= 0; i--) rbf_card_i.q.push_back(seqs[k][2 * i +: 2]);
      drain();
      chk(n_done == ((k % 2) ? 0 : 1), "end symbol");
    end
    $display("end symbol done");
    results();
  end
endmodule
`default_nettype wire
